//--- bench/mpw_tx_model.sv
// transmit side model: sends the pause frame that the block requests
`timescale 1ns/1ns
module mpw_tx_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // pause handshake with the block
  input  wire logic       pause_req,
  input  wire logic [3:0] lat,
  output logic            pause_sent
);
  //////////////////////////////////////////////////////////////////////////////
  logic [3:0] cnt_ff;
  logic       done_ff;
  // one frame per request; lat models a busy line, 0 answers at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff     <= 4'h0;
      done_ff    <= 1'h0;
      pause_sent <= 1'h0;
    end else begin
      pause_sent <= 1'h0;
      if (!pause_req) begin
        cnt_ff  <= 4'h0;
        done_ff <= 1'h0;
      end else if (!done_ff && cnt_ff == lat) begin
        pause_sent <= 1'h1;
        done_ff    <= 1'h1; // no second frame while the request drains
      end else if (!done_ff) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule : mpw_tx_model

//--- bench/testbench.sv
// self-checking testbench of the pause/wake/user io register block
`timescale 1ns/1ns
module testbench;
  import mpw_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  ev = 5'h00; // magic, arp, sa1, mcast, frame done
  logic [15:0] rx_type_length = 16'h0, rx_arp_target_ip = 16'h0, specific_addr4_high;
  logic [15:0] pause_quantum;
  logic        speed_cfg = 1'h0, bit_rate_cfg = 1'h0, full_duplex_config = 1'h1;
  logic        loopback_cfg = 1'h0, external_match_enable = 1'h0;
  logic        type_match, copy_to_memory, mii_mode, pause_req, pause_sent, wake_out, irq;
  logic [3:0]  lat = 4'h6;
  int          n_fail = 0, total_checks = 0;

  //////////////////////////////////////////////////////////////////////////////
  always #4 aclk = ~aclk;
  // byte strobes tied: per-byte enables are not under test here
  mpw_regs i_mpw_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .speed_cfg, .bit_rate_cfg,
    .full_duplex_config, .loopback_cfg, .external_match_enable, .rx_frame_done(ev[4]),
    .rx_type_length, .rx_mcast_hash_hit(ev[3]), .rx_sa1_hit(ev[2]),
    .rx_arp_request(ev[1]), .rx_arp_target_ip, .rx_magic_packet(ev[0]), .type_match,
    .copy_to_memory, .specific_addr4_high, .mii_mode, .pause_req, .pause_quantum,
    .pause_sent, .wake_out, .irq);
  mpw_tx_model i_mpw_tx_model (.aclk, .aresetn, .pause_req, .lat, .pause_sent);

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata  <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk($sformatf("rdata %h", a), exp, s_axi_rdata);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd_reg

  // one-cycle event pulse, returns one edge after the edge that sees it
  task automatic pulse(input logic [4:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 5'h00;
    @(posedge aclk);
  endtask : pulse

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
  endtask : do_reset

  function automatic logic [31:0] img();
    return {12'h000, speed_cfg, bit_rate_cfg, ~full_duplex_config, loopback_cfg, 16'h0000};
  endfunction : img

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_map();
    logic [7:0]  ad [8];
    logic [31:0] ex [8];
    ad = '{OFF_SA4_HIGH, OFF_TYPE_CMP, OFF_PAUSE_Q, OFF_USER_IO, OFF_WAKE_CTL,
           OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_VERSION};
    ex = '{{16'h0, RST_SA4_HIGH}, {16'h0, RST_TYPE_CMP}, {16'h0, RST_PAUSE_Q},
           img() | {28'h0, RST_USER_IO}, {12'h0, RST_WAKE_CTL}, {30'h0, RST_IRQ},
           {30'h0, RST_IRQ}, {VER_PART_REF, VER_NUMBER}};
    foreach (ad[i]) rd_reg(ad[i], ex[i], RESP_OKAY);
    rd_reg(8'h80, 32'h0, RESP_SLVERR);
    wr_reg(8'h80, 32'hffffffff, RESP_SLVERR);
    foreach (ad[i]) if (i < 3) wr_reg(ad[i], 32'hffffffff, RESP_OKAY);
    foreach (ad[i]) if (i < 3) rd_reg(ad[i], 32'h0000ffff, RESP_OKAY);
    wr_reg(OFF_SA4_HIGH, 32'h0000a5c3, RESP_OKAY);
    chk("specific_addr4_high", 32'ha5c3, {16'h0, specific_addr4_high});
    $display("test reset_map done");
  endtask : t_reset_map

  task automatic t_type();
    wr_reg(OFF_TYPE_CMP, 32'h000088f7, RESP_OKAY);
    rx_type_length <= 16'h88f7;
    pulse(5'h10);
    chk("type_match", 32'h1, {31'h0, type_match});
    rx_type_length <= 16'h0800;
    pulse(5'h10);
    chk("type_match", 32'h0, {31'h0, type_match});
    $display("test type done");
  endtask : t_type

  task automatic t_uio();
    {speed_cfg, bit_rate_cfg, full_duplex_config, loopback_cfg} <= 4'h9;
    external_match_enable <= 1'h1;
    wr_reg(OFF_USER_IO, 32'h00000003, RESP_OKAY);
    rd_reg(OFF_USER_IO, img() | 32'h3, RESP_OKAY);
    chk("mii_mode", 32'h1, {31'h0, mii_mode});
    chk("copy_to_memory", 32'h1, {31'h0, copy_to_memory});
    external_match_enable <= 1'h0;
    repeat (2) @(posedge aclk);
    #1;
    chk("copy_to_memory", 32'h0, {31'h0, copy_to_memory});
    wr_reg(OFF_USER_IO, 32'h00000000, RESP_OKAY);
    #1;
    chk("mii_mode", 32'h0, {31'h0, mii_mode});
    $display("test uio done");
  endtask : t_uio

  task automatic t_pause();
    wr_reg(OFF_PAUSE_Q, 32'h00001234, RESP_OKAY);
    wr_reg(OFF_USER_IO, 32'h00000004, RESP_OKAY);
    #1;
    chk("pause_req", 32'h1, {31'h0, pause_req});
    chk("pause_quantum", 32'h1234, {16'h0, pause_quantum});
    repeat (12) @(posedge aclk);
    #1;
    chk("pause_req", 32'h0, {31'h0, pause_req});
    rd_reg(OFF_IRQ_STAT, 32'h2, RESP_OKAY);
    wr_reg(OFF_IRQ_MASK, 32'h2, RESP_OKAY);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    wr_reg(OFF_IRQ_STAT, 32'h2, RESP_OKAY);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    wr_reg(OFF_USER_IO, 32'h00000004, RESP_OKAY);
    lat <= 4'h0; // prompt far side this time
    #1;
    chk("pause_req", 32'h0, {31'h0, pause_req});
    wr_reg(OFF_USER_IO, 32'h00000008, RESP_OKAY);
    #1;
    chk("pause_quantum", 32'h0, {16'h0, pause_quantum});
    $display("test pause done");
  endtask : t_pause

  task automatic t_arp();
    do_reset();
    wr_reg(OFF_WAKE_CTL, 32'h00020000, RESP_OKAY);
    rx_arp_target_ip <= 16'h0000;
    pulse(5'h02);
    chk("wake_out", 32'h0, {31'h0, wake_out});
    wr_reg(OFF_WAKE_CTL, 32'h00025a5a, RESP_OKAY);
    rx_arp_target_ip <= 16'h5a5b;
    pulse(5'h02);
    chk("wake_out", 32'h0, {31'h0, wake_out});
    rx_arp_target_ip <= 16'h5a5a;
    pulse(5'h02);
    chk("wake_out", 32'h1, {31'h0, wake_out});
    $display("test arp done");
  endtask : t_arp

  // each event alone: refused with its own enable clear, taken with it set
  task automatic t_wake();
    // each image at the other level than in the user io test
    {speed_cfg, bit_rate_cfg, full_duplex_config, loopback_cfg} <= 4'h6;
    for (int i = 0; i < 4; i++) begin
      do_reset();
      wr_reg(OFF_WAKE_CTL, (32'h000f0000 ^ (32'h1 << (16 + i))) | 32'h5a5a, RESP_OKAY);
      pulse(5'h01 << i);
      chk("wake_out", 32'h0, {31'h0, wake_out});
      wr_reg(OFF_WAKE_CTL, (32'h1 << (16 + i)) | 32'h5a5a, RESP_OKAY);
      pulse(5'h01 << i);
      chk("wake_out", 32'h1, {31'h0, wake_out});
    end
    rd_reg(OFF_USER_IO, img() | 32'h00100000, RESP_OKAY);
    rd_reg(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    wr_reg(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    wr_reg(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    $display("test wake done");
  endtask : t_wake

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  //////////////////////////////////////////////////////////////////////////////
  // watchdog, far longer than the few hundred cycles the tests take
  initial begin
    #100000;
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset_map();
    t_type();
    t_uio();
    t_pause();
    t_arp();
    t_wake();
    stop_test();
  end
endmodule : testbench

//--- hw/mpw_regs.sv
// pause quantum, type compare, user io and wake-on-lan registers over axi4-lite
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module mpw_regs
  import mpw_pkg::*;
(
  // clock and reset (peripheral bus clock)
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // images of configuration and control bits
  input  wire logic        speed_cfg,
  input  wire logic        bit_rate_cfg,
  input  wire logic        full_duplex_config,
  input  wire logic        loopback_cfg,
  input  wire logic        external_match_enable,
  // receive side events
  input  wire logic        rx_frame_done,
  input  wire logic [15:0] rx_type_length,
  input  wire logic        rx_mcast_hash_hit,
  input  wire logic        rx_sa1_hit,
  input  wire logic        rx_arp_request,
  input  wire logic [15:0] rx_arp_target_ip,
  input  wire logic        rx_magic_packet,
  // receive side control outputs
  output logic             type_match,
  output logic             copy_to_memory,
  output logic [15:0]      specific_addr4_high,
  output logic             mii_mode,
  // pause generation
  output logic             pause_req,
  output logic [15:0]      pause_quantum,
  input  wire logic        pause_sent,
  // wake and interrupt
  output logic             wake_out,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] sa4_high_ff,  nxt_sa4_high;
  logic [15:0] type_cmp_ff,  nxt_type_cmp;
  logic [15:0] pause_q_ff,   nxt_pause_q;
  logic [3:0]  user_io_ff,   nxt_user_io;
  logic [19:0] wake_ctl_ff,  nxt_wake_ctl;
  logic [1:0]  irq_stat_ff,  nxt_irq_stat;
  logic [1:0]  irq_mask_ff,  nxt_irq_mask;
  logic        wake_det_ff,  nxt_wake_det;
  logic        pause_req_ff, nxt_pause_req;
  logic [15:0] pause_qv_ff,  nxt_pause_qv;
  logic        type_hit_ff,  nxt_type_hit;
  logic        copy_ff,      nxt_copy;
  logic        aw_ff, w_ff, bvalid_ff, rvalid_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic [31:0] rdata_ff;
  logic        bresp_err_ff, rresp_err_ff;

  // merge a write into a 32-bit image under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // address is one the block answers to
  function automatic logic mapped(input logic [7:0] a);
    return a == OFF_SA4_HIGH || a == OFF_TYPE_CMP || a == OFF_PAUSE_Q ||
           a == OFF_USER_IO  || a == OFF_WAKE_CTL || a == OFF_IRQ_STAT ||
           a == OFF_IRQ_MASK || a == OFF_VERSION;
  endfunction : mapped

  //////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data captured independently
  // a response still owed blocks both channels, so one write at most is in flight
  wire do_write = aw_ff && w_ff && !bvalid_ff;
  wire [7:0] wa = awaddr_ff;
  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready  = !w_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_err_ff ? RESP_SLVERR : RESP_OKAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      bvalid_ff    <= 1'b0;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      bresp_err_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        bvalid_ff    <= 1'b1;
        bresp_err_ff <= !mapped(wa);
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write decode, merged values
  wire [31:0] m_sa4  = merge({16'h0000, sa4_high_ff}, wdata_ff, wstrb_ff);
  wire [31:0] m_tcmp = merge({16'h0000, type_cmp_ff}, wdata_ff, wstrb_ff);
  wire [31:0] m_pq   = merge({16'h0000, pause_q_ff}, wdata_ff, wstrb_ff);
  wire [31:0] m_uio  = merge({28'h0, user_io_ff}, wdata_ff, wstrb_ff);
  wire [31:0] m_wk   = merge({12'h000, wake_ctl_ff}, wdata_ff, wstrb_ff);
  wire [31:0] m_msk  = merge({30'h0, irq_mask_ff}, wdata_ff, wstrb_ff);
  wire        wr_sa4 = do_write && wa == OFF_SA4_HIGH;
  wire        wr_tc  = do_write && wa == OFF_TYPE_CMP;
  wire        wr_pq  = do_write && wa == OFF_PAUSE_Q;
  wire        wr_uio = do_write && wa == OFF_USER_IO;
  wire        wr_wk  = do_write && wa == OFF_WAKE_CTL;
  wire        wr_st  = do_write && wa == OFF_IRQ_STAT && wstrb_ff[0];
  wire        wr_msk = do_write && wa == OFF_IRQ_MASK;

  assign nxt_sa4_high = wr_sa4 ? m_sa4[15:0] : sa4_high_ff;
  assign nxt_type_cmp = wr_tc  ? m_tcmp[15:0] : type_cmp_ff;
  assign nxt_pause_q  = wr_pq  ? m_pq[15:0] : pause_q_ff;
  assign nxt_user_io  = wr_uio ? m_uio[3:0] : user_io_ff;
  assign nxt_wake_ctl = wr_wk  ? m_wk[19:0] : wake_ctl_ff;
  assign nxt_irq_mask = wr_msk ? m_msk[1:0] : irq_mask_ff;

  //////////////////////////////////////////////////////////////////////////
  // pause trigger: a change of the toggle bit asks for one frame
  wire toggle_edge = wr_uio && (m_uio[UIO_TOGGLE] != user_io_ff[UIO_TOGGLE]);
  wire [15:0] qv   = nxt_user_io[UIO_ZERO_Q] ? 16'h0000 : pause_q_ff;
  // a second toggle while one frame is pending merges into it
  assign nxt_pause_req = toggle_edge ? 1'b1 : (pause_sent ? 1'b0 : pause_req_ff);
  assign nxt_pause_qv  = toggle_edge ? qv : pause_qv_ff;

  //////////////////////////////////////////////////////////////////////////
  // wake event qualification
  wire arp_hit = rx_arp_request && wake_ctl_ff[WK_ARP] &&
                 (wake_ctl_ff[15:0] != 16'h0000) &&
                 (rx_arp_target_ip == wake_ctl_ff[15:0]);
  wire wake_ev = (rx_mcast_hash_hit && wake_ctl_ff[WK_MCAST]) ||
                 (rx_sa1_hit && wake_ctl_ff[WK_SA1]) ||
                 (rx_magic_packet && wake_ctl_ff[WK_MAGIC]) || arp_hit;
  // wake flag sticks; no software clear path, only reset
  assign nxt_wake_det = wake_det_ff | wake_ev;

  // sticky interrupt status, set wins over write-one-to-clear
  wire [1:0] irq_set = {pause_sent && pause_req_ff, wake_ev};
  wire [1:0] irq_clr = wr_st ? wdata_ff[1:0] : 2'b00;
  assign nxt_irq_stat = irq_set | (irq_stat_ff & ~irq_clr);

  // receive side decisions: type compare at frame end, copy enable every cycle
  assign nxt_type_hit = rx_frame_done ? (rx_type_length == type_cmp_ff) : type_hit_ff;
  assign nxt_copy     = user_io_ff[UIO_EXT_M] && external_match_enable;

  //////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sa4_high_ff  <= RST_SA4_HIGH;
      type_cmp_ff  <= RST_TYPE_CMP;
      pause_q_ff   <= RST_PAUSE_Q;
      user_io_ff   <= RST_USER_IO;
      wake_ctl_ff  <= RST_WAKE_CTL;
      irq_stat_ff  <= RST_IRQ;
      irq_mask_ff  <= RST_IRQ;
      wake_det_ff  <= 1'b0;
      pause_req_ff <= 1'b0;
      pause_qv_ff  <= 16'h0000;
      type_hit_ff  <= 1'b0;
      copy_ff      <= 1'b0;
    end else begin
      sa4_high_ff  <= nxt_sa4_high;
      type_cmp_ff  <= nxt_type_cmp;
      pause_q_ff   <= nxt_pause_q;
      user_io_ff   <= nxt_user_io;
      wake_ctl_ff  <= nxt_wake_ctl;
      irq_stat_ff  <= nxt_irq_stat;
      irq_mask_ff  <= nxt_irq_mask;
      wake_det_ff  <= nxt_wake_det;
      pause_req_ff <= nxt_pause_req;
      pause_qv_ff  <= nxt_pause_qv;
      type_hit_ff  <= nxt_type_hit;
      copy_ff      <= nxt_copy;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; address bit zero ordering is left to the filter datapath
  assign specific_addr4_high = sa4_high_ff;
  assign type_match     = type_hit_ff;
  assign copy_to_memory = copy_ff;
  assign mii_mode       = user_io_ff[UIO_IF_SEL];
  assign pause_req      = pause_req_ff;
  assign pause_quantum  = pause_qv_ff;
  assign wake_out       = wake_det_ff;
  assign irq            = |(irq_stat_ff & irq_mask_ff);
  // this block sits entirely in the peripheral bus clock domain

  //////////////////////////////////////////////////////////////////////////
  // read path
  wire [31:0] uio_view = {11'h000, wake_det_ff, speed_cfg, bit_rate_cfg,
                          !full_duplex_config, loopback_cfg,
                          12'h000, user_io_ff};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] rd_mux =
      (ra == OFF_SA4_HIGH) ? {16'h0000, sa4_high_ff} :
      (ra == OFF_TYPE_CMP) ? {16'h0000, type_cmp_ff} :
      (ra == OFF_PAUSE_Q)  ? {16'h0000, pause_q_ff} :
      (ra == OFF_USER_IO)  ? uio_view :
      (ra == OFF_WAKE_CTL) ? {12'h000, wake_ctl_ff} :
      (ra == OFF_IRQ_STAT) ? {30'h0, irq_stat_ff} :
      (ra == OFF_IRQ_MASK) ? {30'h0, irq_mask_ff} :
      (ra == OFF_VERSION)  ? {VER_PART_REF, VER_NUMBER} :
                             32'h0000_0000;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_err_ff ? RESP_SLVERR : RESP_OKAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff    <= 1'b0;
      rdata_ff     <= 32'h0000_0000;
      rresp_err_ff <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff    <= 1'b1;
      rdata_ff     <= rd_mux;
      rresp_err_ff <= !mapped(ra);
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  chk_pause_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    toggle_edge |=> pause_req)
    else $error("toggle did not request pause");
  chk_zero_quantum: assert property (@(posedge aclk) disable iff (!aresetn)
    toggle_edge && nxt_user_io[UIO_ZERO_Q] |=> pause_quantum == 16'h0000)
    else $error("zero quantum not applied");
  chk_prog_quantum: assert property (@(posedge aclk) disable iff (!aresetn)
    toggle_edge && !nxt_user_io[UIO_ZERO_Q] |=> pause_quantum == $past(pause_q_ff))
    else $error("programmed quantum not applied");
  chk_arp_zero_ip: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_ctl_ff[15:0] == 16'h0000 && !wake_out && !rx_mcast_hash_hit &&
    !rx_sa1_hit && !rx_magic_packet |=> !wake_out)
    else $error("zero ip raised wake");
  chk_wake_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_magic_packet && wake_ctl_ff[WK_MAGIC] |=> wake_out)
    else $error("enabled magic packet did not wake");
  chk_wake_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_out |=> wake_out [*3])
    else $error("wake flag dropped");
  chk_half_duplex: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && ra == OFF_USER_IO |=>
    s_axi_rdata[UIO_HALF_DUP] == !$past(full_duplex_config))
    else $error("half duplex image wrong");
  chk_copy_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    copy_to_memory |-> $past(user_io_ff[UIO_EXT_M]) && $past(external_match_enable))
    else $error("copy without match and enable");
  chk_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(ra) == OFF_PAUSE_Q && $rose(s_axi_rvalid) |->
    s_axi_rdata[31:16] == 16'h0000)
    else $error("unused bits not zero");
  chk_if_select: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_uio |=> mii_mode == $past(m_uio[UIO_IF_SEL]))
    else $error("interface select not applied");
  // register bus answers: one per request, none taken while one is owed
  chk_write_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response owed");
  chk_one_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_one_rdata: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  chk_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && ra < OFF_SA4_HIGH |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_version_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && ra == OFF_VERSION |=>
    s_axi_rdata == {VER_PART_REF, VER_NUMBER})
    else $error("version word wrong");
  chk_uio_images: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && ra == OFF_USER_IO |=>
    s_axi_rdata[UIO_SPEED] == $past(speed_cfg) &&
    s_axi_rdata[UIO_BIT_RATE] == $past(bit_rate_cfg) &&
    s_axi_rdata[UIO_LOOPBACK] == $past(loopback_cfg))
    else $error("configuration images wrong");
  // receive side, wake and pause
  chk_type_compare: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_frame_done |=> type_match == ($past(rx_type_length) == $past(type_cmp_ff)))
    else $error("type compare result wrong");
  chk_arp_match: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_arp_request && wake_ctl_ff[WK_ARP] && wake_ctl_ff[15:0] != 16'h0000 &&
    rx_arp_target_ip == wake_ctl_ff[15:0] |=> wake_out)
    else $error("matching arp did not wake");
  chk_wake_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    !wake_out && !(rx_mcast_hash_hit && wake_ctl_ff[WK_MCAST]) &&
    !(rx_sa1_hit && wake_ctl_ff[WK_SA1]) && !(rx_magic_packet && wake_ctl_ff[WK_MAGIC]) &&
    !(rx_arp_request && wake_ctl_ff[WK_ARP]) |=> !wake_out)
    else $error("wake without enabled event");
  chk_pause_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    pause_req && !pause_sent && !toggle_edge |=> pause_req && $stable(pause_quantum))
    else $error("pending pause request changed");
  chk_irq_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_ev |=> irq_stat_ff[IRQ_WAKE])
    else $error("wake status not set");

  cov_pause: cover property (@(posedge aclk) disable iff (!aresetn)
    toggle_edge ##[1:20] pause_sent);
  cov_arp_wake: cover property (@(posedge aclk) disable iff (!aresetn) arp_hit);
  cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  cov_zero_pause: cover property (@(posedge aclk) disable iff (!aresetn)
    toggle_edge && nxt_user_io[UIO_ZERO_Q]);
  cov_bus_error: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : mpw_regs

//--- inc/mpw_pkg.sv
// package: register map, fields and reset values of the pause/wake/user-io block
package mpw_pkg;
  // byte offsets
  localparam logic [7:0] OFF_SA4_HIGH  = 8'hb4;
  localparam logic [7:0] OFF_TYPE_CMP  = 8'hb8;
  localparam logic [7:0] OFF_PAUSE_Q   = 8'hbc;
  localparam logic [7:0] OFF_USER_IO   = 8'hc0;
  localparam logic [7:0] OFF_WAKE_CTL  = 8'hc4;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'hc8;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'hcc;
  localparam logic [7:0] OFF_VERSION   = 8'hfc;
  // reset values
  localparam logic [15:0] RST_SA4_HIGH = 16'h0000;
  localparam logic [15:0] RST_TYPE_CMP = 16'h0000;
  localparam logic [15:0] RST_PAUSE_Q  = 16'hffff;
  localparam logic [3:0]  RST_USER_IO  = 4'h0;
  localparam logic [19:0] RST_WAKE_CTL = 20'h0ffff;
  localparam logic [1:0]  RST_IRQ      = 2'h0;
  // arbitrary identification values, no meaning
  localparam logic [15:0] VER_NUMBER   = 16'h0001;
  localparam logic [15:0] VER_PART_REF = 16'h0000;
  // user io field positions
  localparam int UIO_IF_SEL   = 0;
  localparam int UIO_EXT_M    = 1;
  localparam int UIO_TOGGLE   = 2;
  localparam int UIO_ZERO_Q   = 3;
  localparam int UIO_LOOPBACK = 16;
  localparam int UIO_HALF_DUP = 17;
  localparam int UIO_BIT_RATE = 18;
  localparam int UIO_SPEED    = 19;
  localparam int UIO_WAKE     = 20;
  // wake control field positions
  localparam int WK_MAGIC = 16;
  localparam int WK_ARP   = 17;
  localparam int WK_SA1   = 18;
  localparam int WK_MCAST = 19;
  // interrupt status bit positions
  localparam int IRQ_WAKE  = 0;
  localparam int IRQ_PAUSE = 1;
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : mpw_pkg
